//--- core/spm_ctrl.v
// Purpose: sleep / idle power-mode controller with wake sequencing
// Assumes: core signals share clk_i; ready inputs come from analog/pins
// Notes:   registers over classic wishbone, one wait state per access
//
// What this block does
// - sleep instruction with idle_select 0 enters full sleep.
// - sleep entry clears watchdog; it keeps counting only if sleep-enabled.
// - sleep entry clears power_down_flag and sets timeout_flag.
// - sleep stops the cpu clock; other oscillators keep running.
// - i/o ports hold their drive state while asleep.
// - sleep changes no reset source except the watchdog.
// - resets leave sleep by reset; any enabled non clock-switch interrupt wakes.
// - interrupt wakes only if its enable is set, whatever global enable.
// - sleep instruction prefetches the instruction at pc plus two.
// - interrupt wake without global enable resumes inline; with it, then isr call.
// - watchdog is cleared on every wake from sleep.
// - execution waits for flash, oscillator and brown-out readiness.
// - pending enabled interrupt makes sleep a no-op, flags untouched.
// - interrupt during sleep instruction completes it then wakes at once.
// - crystal modes add 1024 oscillator periods start-up on wake.
// - with global enable set the isr is called at vector 0004h.
// - regulator_power_mode set adds extra stabilization delay on wake.
// - idle_select 1 makes sleep enter idle; peripheral clocks run.
// - any enabled non clock-switch interrupt ends idle, idle_select kept; sleep re-enters idle.
// - recover_on_interrupt with doze on: idle interrupt restores full speed.
// - watchdog timeout in idle wakes, no reset, doze_enable unchanged.
// - sleep stops only system clock and its quarter; idle stops only the cpu clock.
// - isr entry with recover_on_interrupt clears doze_enable.
// - regulator_power_mode is bit 1 of regulator control, reset 0.
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "spm_consts.vh"

module spm_ctrl
(
  input  wire                   clk_i,
  input  wire                   rst_i,
  // wishbone slave
  input  wire                   cyc_i,
  input  wire                   stb_i,
  input  wire                   we_i,
  input  wire [3:0]             adr_i,
  input  wire [3:0]             sel_i,
  input  wire [31:0]            dat_i,
  output reg  [31:0]            dat_o,
  output reg                    ack_o,
  // core side
  input  wire                   sleep_instr_i,
  input  wire [15:0]            pc_i,
  input  wire                   isr_enter_i,
  input  wire                   retfie_i,
  input  wire                   global_irq_enable_i,
  input  wire [`SPM_IRQ_W-1:0]  irq_flag_i,
  input  wire [`SPM_IRQ_W-1:0]  irq_enable_i,
  input  wire                   wdt_timeout_i,
  // readiness from outside the clock domain
  input  wire                   flash_ready_i,
  input  wire                   osc_ready_i,
  input  wire                   brownout_ready_i,
  // outputs
  output reg  [1:0]             power_state_o,
  output reg                    cpu_clk_en_o,
  output reg                    sysclk_en_o,
  output reg                    io_hold_o,
  output reg                    wdt_clear_o,
  output reg                    wdt_run_o,
  output reg                    wdt_reset_o,
  output reg                    prefetch_o,
  output reg  [15:0]            prefetch_addr_o,
  output reg                    resume_o,
  output reg                    isr_call_o,
  output reg  [15:0]            isr_vector_o,
  output reg                    lp_regulator_o,
  output reg                    doze_enable_o,
  output reg  [2:0]             doze_ratio_o,
  output reg                    power_down_flag_o,
  output reg                    timeout_flag_o
);

  // ****************************************************************
  // constants and state codes
  // ****************************************************************
  localparam integer OST_INT     = `SPM_OST_PERIODS - 1;
  localparam integer LP_STAB_CYC = (`SPM_LP_STAB_NS * `SPM_CLK_MHZ + 999) / 1000;
  localparam integer LP_INT      = LP_STAB_CYC - 1;
  localparam [`SPM_CNT_W-1:0] OST_CYC = OST_INT[`SPM_CNT_W-1:0];
  localparam [`SPM_CNT_W-1:0] LP_CYC  = LP_INT[`SPM_CNT_W-1:0];
  localparam [7:0]   CFG_RST     = `SPM_RST_CONFIG;   // named so its fields can be sliced
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_OST   = 3'h3;
  localparam [2:0] ST_STAB  = 3'h4;
  localparam [2:0] ST_READY = 3'h5;
  localparam [2:0] ST_WAKE  = 3'h6;
  // enabled interrupt that may wake, clock-switch excluded
  function wake_irq;
    input [`SPM_IRQ_W-1:0] flg;
    input [`SPM_IRQ_W-1:0] ena;
    begin
      wake_irq = |(flg & ena & `SPM_IRQ_CSW_MASK);
    end
  endfunction

  // ****************************************************************
  // state and register storage
  // ****************************************************************
  reg [2:0]             state, next_state;
  reg [`SPM_CNT_W-1:0]  cnt, next_cnt;
  reg [1:0]             osc_mode;
  reg                   reg_pm, idle_select, recover_on_interrupt, doe, bor_en, wdt_slp_en;
  reg                   wdt_wake, next_wdt_wake, next_doze, next_pd, next_to;
  reg                   next_wdt_clear, next_wdt_reset, next_resume, next_isr, idle_clr_doze;
  reg [2:0]             rdy_s1, rdy_s2, rdy_s3, rdy;
  wire pending  = wake_irq(irq_flag_i, irq_enable_i);
  wire wb_req   = cyc_i & stb_i & ~ack_o;
  wire wb_wr    = wb_req & we_i & sel_i[0];
  wire all_rdy  = rdy[0] & rdy[1] & (rdy[2] | ~bor_en);
  wire crystal  = (osc_mode == `SPM_OSC_CRYSTAL);

  // ****************************************************************
  // readiness synchronisers
  // ****************************************************************
  // three stages; a change counts once stages two and three agree,
  // so a single-cycle glitch on a ready line never starts the core
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdy_s1 <= 3'h0;
      rdy_s2 <= 3'h0;
      rdy_s3 <= 3'h0;
      rdy    <= 3'h0;
    end
    else
    begin
      rdy_s1 <= {brownout_ready_i, osc_ready_i, flash_ready_i};
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
      rdy    <= (rdy_s2 & rdy_s3) | (rdy & (rdy_s2 | rdy_s3));
    end
  end

  // ****************************************************************
  // power sequencer
  // ****************************************************************
  // next-state and event decode
  always @*
  begin
    next_state     = state;
    next_cnt       = cnt;
    next_pd        = power_down_flag_o;
    next_to        = timeout_flag_o;
    next_wdt_clear = 1'b0;
    next_wdt_reset = 1'b0;
    next_resume    = 1'b0;
    next_isr       = 1'b0;
    next_wdt_wake  = wdt_wake;
    idle_clr_doze  = 1'b0;
    case (state)
      ST_RUN:
      begin
        // an enabled flag already up turns sleep into a no-op
        if (sleep_instr_i && !pending)
        begin
          next_pd       = 1'b0;
          next_to       = 1'b1;
          next_wdt_wake = 1'b0;
          if (idle_select)
            next_state = ST_IDLE;
          else
          begin
            next_state     = ST_SLEEP;
            next_wdt_clear = 1'b1;
          end
        end
      end
      ST_IDLE:
      begin
        if (pending)
        begin
          next_state    = ST_WAKE;
          idle_clr_doze = recover_on_interrupt;
        end
        else if (wdt_timeout_i)
        begin
          next_state    = ST_WAKE;
          next_wdt_wake = 1'b1;
        end
      end
      ST_SLEEP:
      begin
        // interrupt arriving after the instruction wakes at once
        if (pending)
        begin
          next_wdt_clear = 1'b1;
          next_cnt       = crystal ? OST_CYC : LP_CYC;
          if (crystal)
            next_state = ST_OST;
          else if (reg_pm)
            next_state = ST_STAB;
          else
            next_state = ST_READY;
        end
        else if (wdt_timeout_i && wdt_slp_en)
          next_wdt_reset = 1'b1;
      end
      ST_OST:
      begin
        if (cnt == {`SPM_CNT_W{1'b0}})
        begin
          next_cnt   = LP_CYC;
          next_state = reg_pm ? ST_STAB : ST_READY;
        end
        else
          next_cnt = cnt - 1'b1;
      end
      ST_STAB:
      begin
        if (cnt == {`SPM_CNT_W{1'b0}})
          next_state = ST_READY;
        else
          next_cnt = cnt - 1'b1;
      end
      ST_READY:
      begin
        if (all_rdy)
          next_state = ST_WAKE;
      end
      ST_WAKE:
      begin
        next_state  = ST_RUN;
        next_resume = 1'b1;
        // watchdog wake is no interrupt, so no vectoring
        next_isr    = global_irq_enable_i & ~wdt_wake;
      end
      default:
        next_state = ST_RUN;
    endcase
  end

  // sequencer registers and core-facing outputs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state             <= ST_RUN;
      cnt               <= {`SPM_CNT_W{1'b0}};
      wdt_wake          <= 1'b0;
      power_down_flag_o <= 1'b1;
      timeout_flag_o    <= 1'b1;
      wdt_clear_o       <= 1'b0;
      wdt_reset_o       <= 1'b0;
      resume_o          <= 1'b0;
      isr_call_o        <= 1'b0;
      isr_vector_o      <= 16'h0000;
      prefetch_o        <= 1'b0;
      prefetch_addr_o   <= 16'h0000;
      power_state_o     <= `SPM_PS_RUN;
      cpu_clk_en_o      <= 1'b1;
      sysclk_en_o       <= 1'b1;
      io_hold_o         <= 1'b0;
      wdt_run_o         <= 1'b1;
    end
    else
    begin
      state             <= next_state;
      cnt               <= next_cnt;
      wdt_wake          <= next_wdt_wake;
      power_down_flag_o <= next_pd;
      timeout_flag_o    <= next_to;
      wdt_clear_o       <= next_wdt_clear;
      wdt_reset_o       <= next_wdt_reset;
      resume_o          <= next_resume;
      isr_call_o        <= next_isr;
      isr_vector_o      <= next_isr ? `SPM_ISR_VECTOR : 16'h0000;
      // fetch the next word while sleep executes
      prefetch_o        <= sleep_instr_i & (state == ST_RUN);
      if (sleep_instr_i && state == ST_RUN)
        prefetch_addr_o <= pc_i + `SPM_PC_STEP;
      // run, idle, or sleep; the wake step keeps whichever of idle or sleep came before
      case (next_state)
        ST_RUN:  power_state_o <= `SPM_PS_RUN;
        ST_IDLE: power_state_o <= `SPM_PS_IDLE;
        ST_WAKE: power_state_o <= power_state_o;
        default: power_state_o <= `SPM_PS_SLEEP;
      endcase
      cpu_clk_en_o <= (next_state == ST_RUN);
      // only the system clock and its quarter stop; other sources are
      // not gated here, so peripherals on them keep running
      sysclk_en_o  <= (next_state == ST_RUN) || (next_state == ST_IDLE)
                      || (next_state == ST_WAKE && state == ST_IDLE);
      io_hold_o    <= (next_state != ST_RUN) && (next_state != ST_IDLE)
                      && !(next_state == ST_WAKE && state == ST_IDLE);
      // watchdog keeps counting in sleep only when enabled for it
      wdt_run_o    <= (next_state == ST_SLEEP) ? wdt_slp_en : 1'b1;
    end
  end

  // ****************************************************************
  // doze control
  // ****************************************************************
  // software write first, then hardware clear, then hardware set,
  // so a hardware event in the same cycle always wins
  always @*
  begin
    next_doze = doze_enable_o;
    if (wb_wr && adr_i[3:2] == `SPM_IDX_DOZE)
      next_doze = dat_i[`SPM_BIT_DOZE_EN];
    if ((isr_enter_i && recover_on_interrupt) || idle_clr_doze)
      next_doze = 1'b0;
    if (retfie_i && doe)
      next_doze = 1'b1;
  end

  // ****************************************************************
  // wishbone slave and registers
  // ****************************************************************
  // one wait state: ack one cycle after the request, dropped after
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o          <= 1'b0;
      dat_o          <= 32'h0000_0000;
      reg_pm         <= `SPM_RST_REG_PM;
      idle_select    <= 1'b0;
      recover_on_interrupt            <= 1'b0;
      doe            <= 1'b0;
      doze_enable_o  <= 1'b0;
      doze_ratio_o   <= `SPM_RST_DOZE_RATIO;
      osc_mode       <= CFG_RST[`SPM_MSB_OSC_MODE:0];
      bor_en         <= CFG_RST[`SPM_BIT_BOR_EN];
      wdt_slp_en     <= CFG_RST[`SPM_BIT_WDT_SLP_EN];
      lp_regulator_o <= 1'b0;
    end
    else
    begin
      ack_o          <= wb_req;
      doze_enable_o  <= next_doze;
      lp_regulator_o <= reg_pm & (state == ST_SLEEP);
      if (wb_wr)
      begin
        case (adr_i[3:2])
          `SPM_IDX_REGCTL:
            reg_pm <= dat_i[`SPM_BIT_REG_PM];
          `SPM_IDX_DOZE:
          begin
            // hardware never touches idle_select
            idle_select  <= dat_i[`SPM_BIT_IDLE_SEL];
            recover_on_interrupt          <= dat_i[`SPM_BIT_ROI];
            doe          <= dat_i[`SPM_BIT_DOE];
            doze_ratio_o <= dat_i[`SPM_MSB_DOZE_RATIO:0];
          end
          `SPM_IDX_CONFIG:
          begin
            osc_mode   <= dat_i[`SPM_MSB_OSC_MODE:0];
            bor_en     <= dat_i[`SPM_BIT_BOR_EN];
            wdt_slp_en <= dat_i[`SPM_BIT_WDT_SLP_EN];
          end
          default:
            reg_pm <= reg_pm;
        endcase
      end
      // read data is captured with the ack; other times zero
      dat_o <= 32'h0000_0000;
      if (wb_req && !we_i)
      begin
        case (adr_i[3:2])
          `SPM_IDX_REGCTL:
          begin
            dat_o[`SPM_BIT_REG_PM]   <= reg_pm;
            dat_o[`SPM_BIT_REG_RSVD] <= 1'b1;
          end
          `SPM_IDX_DOZE:
          begin
            dat_o[`SPM_BIT_IDLE_SEL]       <= idle_select;
            dat_o[`SPM_BIT_DOZE_EN]        <= doze_enable_o;
            dat_o[`SPM_BIT_ROI]            <= recover_on_interrupt;
            dat_o[`SPM_BIT_DOE]            <= doe;
            dat_o[`SPM_MSB_DOZE_RATIO:0]   <= doze_ratio_o;
          end
          `SPM_IDX_STATUS:
          begin
            dat_o[`SPM_BIT_TO_FLAG]                       <= timeout_flag_o;
            dat_o[`SPM_BIT_PD_FLAG]                       <= power_down_flag_o;
            dat_o[`SPM_LSB_PSTATE+1:`SPM_LSB_PSTATE]      <= power_state_o;
            dat_o[`SPM_BIT_WDT_WAKE]                      <= wdt_wake;
          end
          default:
          begin
            dat_o[`SPM_MSB_OSC_MODE:0]     <= osc_mode;
            dat_o[`SPM_BIT_BOR_EN]         <= bor_en;
            dat_o[`SPM_BIT_WDT_SLP_EN]     <= wdt_slp_en;
          end
        endcase
      end
    end
  end
endmodule // spm_ctrl

//--- include/spm_consts.vh
// Purpose: constants for the sleep/idle power-mode controller
// Assumes: 32-bit classic wishbone, 25 MHz system clock
// Notes:   definitions only
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

// ****************************************************************
// register map (byte addresses, word index on adr[3:2])
// ****************************************************************
`define SPM_IDX_REGCTL       2'h0
`define SPM_IDX_DOZE         2'h1
`define SPM_IDX_STATUS       2'h2
`define SPM_IDX_CONFIG       2'h3

// regulator_control_reg fields
`define SPM_BIT_REG_PM       1
`define SPM_BIT_REG_RSVD     0
`define SPM_RST_REG_PM       1'b0

// doze_idle_control_reg fields
`define SPM_BIT_IDLE_SEL     7
`define SPM_BIT_DOZE_EN      6
`define SPM_BIT_ROI          5
`define SPM_BIT_DOE          4
`define SPM_MSB_DOZE_RATIO   2
`define SPM_RST_DOZE_RATIO   3'h0

// status fields
`define SPM_BIT_TO_FLAG      0
`define SPM_BIT_PD_FLAG      1
`define SPM_LSB_PSTATE       2
`define SPM_BIT_WDT_WAKE     4

// config fields
`define SPM_MSB_OSC_MODE     1
`define SPM_BIT_BOR_EN       2
`define SPM_BIT_WDT_SLP_EN   3
`define SPM_RST_CONFIG       8'h04

// oscillator modes
`define SPM_OSC_CRYSTAL      2'h0
`define SPM_OSC_EXT_CLK      2'h1
`define SPM_OSC_INT_OSC      2'h2

// power states on the encoded output
`define SPM_PS_RUN           2'h0
`define SPM_PS_IDLE          2'h1
`define SPM_PS_SLEEP         2'h2

// interrupt lines; line 0 is the clock-switch interrupt
`define SPM_IRQ_W            8
`define SPM_IRQ_CSW_MASK     8'hfe

// timing
`define SPM_CLK_MHZ          25
`define SPM_OST_PERIODS      1024
`define SPM_LP_STAB_NS       20000
`define SPM_CNT_W            11
`define SPM_ISR_VECTOR       16'h0004
`define SPM_PC_STEP          16'h0002

`endif

//--- tb/spm_core_model.sv
// Purpose: core and readiness side facing the power-mode controller
// Assumes: vector fetch one cycle after the service call
// Notes:   slow_i makes readiness come back late after sleep entry
`timescale 1ns/1ps
`include "spm_consts.vh"

module spm_core_model
(
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       slow_i,
  input  wire [1:0] power_state_i,
  input  wire       isr_call_i,
  output reg        isr_enter_o,
  output wire       flash_ready_o,
  output wire       osc_ready_o,
  output wire       brownout_ready_o
);
  int cnt;

  // ****************************************************************
  // vector entry and stay-in-sleep counter
  // ****************************************************************
  always @(posedge clk_i)
  begin
    isr_enter_o <= isr_call_i && !rst_i;
    if (rst_i || power_state_i != `SPM_PS_SLEEP)
      cnt <= 0;
    else
      cnt <= cnt + 1;
  end

  // readiness returns in stages; the oscillator is the last one
  assign flash_ready_o    = !slow_i || cnt >= 300;
  assign brownout_ready_o = !slow_i || cnt >= 600;
  assign osc_ready_o      = !slow_i || cnt >= 1200;
endmodule // spm_core_model

//--- tb/spm_ctrl_properties.sv
// Purpose: port-level timing checks for the power-mode controller
// Assumes: bound to spm_ctrl, one clock, synchronous active-high reset
// Notes:   long wake counts and readiness waits are judged by the bench
`timescale 1ns/1ps
`include "spm_consts.vh"

module spm_ctrl_properties
(
  input wire                  clk_i,
  input wire                  rst_i,
  input wire                  cyc_i,
  input wire                  stb_i,
  input wire                  ack_o,
  input wire                  sleep_instr_i,
  input wire [15:0]           pc_i,
  input wire [`SPM_IRQ_W-1:0] irq_flag_i,
  input wire [`SPM_IRQ_W-1:0] irq_enable_i,
  input wire                  wdt_timeout_i,
  input wire [1:0]            power_state_o,
  input wire                  cpu_clk_en_o,
  input wire                  sysclk_en_o,
  input wire                  wdt_clear_o,
  input wire                  prefetch_o,
  input wire [15:0]           prefetch_addr_o,
  input wire                  resume_o,
  input wire                  isr_call_o,
  input wire [15:0]           isr_vector_o,
  input wire                  power_down_flag_o,
  input wire                  timeout_flag_o
);
  // ****************************************************************
  // helper terms
  // ****************************************************************
  // the clock-switch line is masked: it must never count as pending
  wire pend;
  wire run;
  assign pend = |(irq_flag_i & irq_enable_i & `SPM_IRQ_CSW_MASK);
  assign run  = power_state_o == `SPM_PS_RUN;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************************************
  // properties
  // ****************************************************************
  property p_ack;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack is not one pulse");
  property p_entry;
    run && sleep_instr_i && !pend |=> !run && !cpu_clk_en_o
      && !power_down_flag_o && timeout_flag_o;
  endproperty
  a_entry: assert property (p_entry) else $error("bad sleep entry");
  property p_nop;
    run && sleep_instr_i && pend |=> run && !wdt_clear_o
      && $stable(power_down_flag_o) && $stable(timeout_flag_o);
  endproperty
  a_nop: assert property (p_nop) else $error("pending sleep not a no-op");
  property p_prefetch;
    run && sleep_instr_i |=> prefetch_o && prefetch_addr_o == $past(pc_i) + `SPM_PC_STEP;
  endproperty
  a_prefetch: assert property (p_prefetch) else $error("bad prefetch");
  property p_sleep_clk;
    power_state_o == `SPM_PS_SLEEP |-> !cpu_clk_en_o && !sysclk_en_o;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("clock runs in sleep");
  property p_idle_clk;
    power_state_o == `SPM_PS_IDLE |-> !cpu_clk_en_o && sysclk_en_o;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("bad idle clocks");
  property p_wdt_clr;
    run ##1 power_state_o == `SPM_PS_SLEEP |-> wdt_clear_o;
  endproperty
  a_wdt_clr: assert property (p_wdt_clr) else $error("no watchdog clear");
  property p_idle_wake;
    power_state_o == `SPM_PS_IDLE && (pend || wdt_timeout_i) |-> ##[1:2] (resume_o && cpu_clk_en_o);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not left");
  property p_vec;
    isr_call_o |-> resume_o && isr_vector_o == `SPM_ISR_VECTOR;
  endproperty
  a_vec: assert property (p_vec) else $error("bad service call");
endmodule // spm_ctrl_properties

bind spm_ctrl spm_ctrl_properties i_spm_ctrl_properties
(
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .sleep_instr_i, .pc_i, .irq_flag_i,
  .irq_enable_i, .wdt_timeout_i, .power_state_o, .cpu_clk_en_o, .sysclk_en_o,
  .wdt_clear_o, .prefetch_o, .prefetch_addr_o, .resume_o, .isr_call_o,
  .isr_vector_o, .power_down_flag_o, .timeout_flag_o
);

//--- tb/tb.sv
// Purpose: self-checking bench for the power-mode controller
// Assumes: wishbone answers one cycle after the take edge
// Notes:   pc and wake lines come from a fixed-seed lfsr
`timescale 1ns/1ps
`include "spm_consts.vh"

module tb;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  reg         clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, slp = 0;
  reg         retfie = 0, global_irq_enable = 0, wdt_hit = 0, slow = 0, got_call, got_clr;
  reg  [3:0]  adr = 0, sel = 4'hf;
  reg  [31:0] dat = 0, seed = 32'h0980, rd;
  reg  [15:0] pc = 0;
  reg  [7:0]  flg = 0, ena = 0;
  wire [2:0]  ratio;
  int         n_mismatch = 0, n_compared = 0, cycles = 0, n;
  wire [1:0]  pst;
  wire [31:0] dat_o;
  wire [15:0] pre_adr;
  wire        ack, cpu_en, sys_en, clr, pre, resume, call, doze, pdn, tmo, wrun, wrst;
  wire        isr_in, lp, f_rdy, o_rdy, b_rdy, hold;

  spm_ctrl i_spm_ctrl
  (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .sleep_instr_i(slp),
    .pc_i(pc), .isr_enter_i(isr_in), .retfie_i(retfie), .global_irq_enable_i(global_irq_enable),
    .irq_flag_i(flg), .irq_enable_i(ena), .wdt_timeout_i(wdt_hit),
    .flash_ready_i(f_rdy), .osc_ready_i(o_rdy), .brownout_ready_i(b_rdy),
    .power_state_o(pst), .cpu_clk_en_o(cpu_en), .sysclk_en_o(sys_en), .io_hold_o(hold),
    .wdt_clear_o(clr), .wdt_run_o(wrun), .wdt_reset_o(wrst), .prefetch_o(pre),
    .prefetch_addr_o(pre_adr), .resume_o(resume), .isr_call_o(call), .isr_vector_o(),
    .lp_regulator_o(lp), .doze_enable_o(doze), .doze_ratio_o(ratio),
    .power_down_flag_o(pdn), .timeout_flag_o(tmo)
  );

  spm_core_model i_spm_core_model
  (
    .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .power_state_i(pst), .isr_call_i(call),
    .isr_enter_o(isr_in), .flash_ready_o(f_rdy), .osc_ready_o(o_rdy),
    .brownout_ready_o(b_rdy)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  always #20 clk_i = ~clk_i;

  // a hang is cut short well above the longest wake sequence
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_mismatch++;
      stop_test;
    end
  end

  function automatic [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input [31:0] seen, input [31:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  end
  endtask

  // one classic cycle; read data taken at the ack edge only
  task automatic wb(input w, input [3:0] a, input [31:0] d);
  begin
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    // no fixed wait: only the cycle ceiling ends a missing ack
    while (ack !== 1'b1)
      @(posedge clk_i);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  end
  endtask

  task automatic go_sleep;
  begin
    seed = lfsr(seed);
    @(posedge clk_i);
    slp <= 1'b1;
    pc  <= seed[15:0];
    @(posedge clk_i);
    slp <= 1'b0;
    @(negedge clk_i);
    chk(pre, 1'b1);
    chk(pre_adr, 16'(pc + 16'h0002));
  end
  endtask

  // raise a random enabled line (or the watchdog) and count to resume
  task automatic wake(input use_wdt);
  begin
    seed = lfsr(seed);
    n = 0;
    got_clr = 0;
    @(posedge clk_i);
    flg <= use_wdt ? 8'h00 : {seed[7:2], 1'b1, seed[0]};
    ena <= use_wdt ? 8'h00 : {seed[7:2], 1'b1, seed[0]};
    wdt_hit <= use_wdt;
    while (resume !== 1'b1 && n < 3000)
    begin
      @(negedge clk_i);
      got_clr = got_clr | (clr === 1'b1);
      n++;
    end
    got_call = call;
    @(posedge clk_i);
    flg <= 8'h00;
    ena <= 8'h00;
    wdt_hit <= 1'b0;
  end
  endtask

  task automatic stop_test;
  begin
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 4'h0, 0);
    chk(rd, 32'h1);
    wb(1, 4'h8, 0);
    wb(0, 4'h8, 0);
    chk(rd, 32'h3);
    wb(1, 4'h0, 32'h2);
    wb(0, 4'h0, 0);
    chk(rd, 32'h3);
    $display("test registers done");
    // crystal mode, service call on wake, doze cleared then restored
    wb(1, 4'h0, 0);
    wb(1, 4'h4, 32'h70);
    global_irq_enable <= 1'b1;
    go_sleep;
    chk(pst, `SPM_PS_SLEEP);
    chk({pdn, tmo, wrun, hold}, 4'b0101);
    @(posedge clk_i);
    flg <= 8'h05;
    ena <= 8'h01;
    repeat (40) @(posedge clk_i);
    chk({pst, resume}, {`SPM_PS_SLEEP, 1'b0});
    wake(0);
    chk(n >= 1024 && n <= 1045, 1);
    chk({got_call, got_clr}, 2'b11);
    repeat (3) @(negedge clk_i);
    chk(doze, 0);
    @(posedge clk_i);
    retfie <= 1'b1;
    @(posedge clk_i);
    retfie <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk(doze, 1);
    $display("test crystal wake done");
    // external clock then internal oscillator, watchdog kept running, no service call
    wb(1, 4'h4, 0);
    wb(1, 4'hc, 32'h0d);
    global_irq_enable <= 1'b0;
    go_sleep;
    chk(wrun, 1);
    @(posedge clk_i);
    wdt_hit <= 1'b1;
    @(posedge clk_i);
    wdt_hit <= 1'b0;
    @(negedge clk_i);
    chk({wrst, pst}, {1'b1, `SPM_PS_SLEEP});
    wake(0);
    chk({n <= 10, got_call}, 2'b10);
    wb(1, 4'h0, 32'h2);
    wb(1, 4'hc, 32'h0e);
    go_sleep;
    @(negedge clk_i); // regulator flag follows the sleep state one cycle later
    chk(lp, 1);
    wake(0);
    chk(n >= 500 && n <= 515, 1);
    wb(1, 4'h0, 0);
    slow <= 1'b1;
    go_sleep;
    repeat (10) @(posedge clk_i);
    wake(0);
    chk(n >= 1185 && n <= 1205, 1);
    slow <= 1'b0;
    $display("test wake timing done");
    // pending enabled line turns sleep into a no-op
    // mid-run reset sets both flags, so a wrong entry would show
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    flg <= 8'h10;
    ena <= 8'h10;
    go_sleep;
    chk({pst, pdn, tmo}, {`SPM_PS_RUN, 2'b11});
    @(posedge clk_i);
    flg <= 8'h00;
    ena <= 8'h00;
    // idle entry, interrupt wake with recovery, then watchdog wake
    wb(1, 4'h4, 32'he1);
    go_sleep;
    chk({pst, sys_en, hold, ratio}, {`SPM_PS_IDLE, 1'b1, 1'b0, 3'h1});
    wake(0);
    chk({n <= 4, doze}, 2'b10);
    wb(0, 4'h4, 0);
    chk(rd[7], 1);
    wb(1, 4'h4, 32'he1);
    go_sleep;
    chk(pst, `SPM_PS_IDLE);
    wake(1);
    chk({n <= 4, doze, wrst}, 3'b110);
    $display("test idle done");
    stop_test;
  end
endmodule // tb
